// ---- verilog/crie_irq_logic.sv ----
// interrupt enable, state-change detection and apb register file
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
// What this block does
// [R1] wake-up event requests wake-up interrupt only when wake-up enable set
// [R2] status change flag requests error interrupt only when its enable set
// [R3] rx sensitivity picks which receiver state changes set the change flag
// [R4] tx sensitivity picks which transmitter state changes set the change flag
// [R5] rx state flags track actual state, updated only while no flag pending
// [R6] tx state flags track actual state, updated only while no flag pending
// [R7] overrun event requests error interrupt only when overrun enable set
// [R8] receive full event requests receiver interrupt when its enable set
// [R9] stop or wait recovery needs both wake-up enables set
// [R10] receiver state code has an extra bus-off value
// [R11] tx leaving bus-off to ok forces receiver straight to ok
// [R12] each request except recover_o is high while its flag and its enable are both set
module crie_irq_logic (
	// clock and reset
	input  wire logic                    clock_i,
	input  wire logic                    rst_n_i,
	// apb slave
	input  wire logic                    psel_i,
	input  wire logic                    penable_i,
	input  wire logic                    pwrite_i,
	input  wire logic [7:0]              paddr_i,
	input  wire logic [31:0]             pwdata_i,
	output logic      [31:0]             prdata_o,
	output logic                         pready_o,
	output logic                         pslverr_o,
	// controller core
	input  wire crie_pkg::crie_event_type events_i,
	input  wire crie_pkg::crie_state_type rx_state_i,
	input  wire crie_pkg::crie_state_type tx_state_i,
	input  wire logic                    low_power_i,
	// requests
	output logic                         wakeup_irq_o,
	output logic                         error_irq_o,
	output logic                         rx_irq_o,
	output logic                         recover_o,
	output logic                         irq_o
);
	import crie_pkg::*;

	logic [7:0]      enable_q;
	logic            wake_fn_q;
	logic [EV_N-1:0] status_q, status_d, mask_q, ev_set;
	logic            csc_q, ovr_q, rxf_q, wake_q;
	crie_state_type  rx_flag_q, tx_flag_q, rx_eff;
	logic            rx_hit, tx_hit, csc_set, csc_clr;
	logic            wr_en, rd_en, hit, flags_wr;
	logic [31:0]     rd_mux;

	// true when a change between two codes matters at this sensitivity
	function automatic logic sens_hit(input logic [1:0] s,
		input crie_state_type a, input crie_state_type b);
		logic boff, err;
		boff = (a == ST_BUS_OFF) != (b == ST_BUS_OFF);
		err  = boff || ((a == ST_ERR) != (b == ST_ERR));
		unique case (s)
			SENS_NONE: sens_hit = 1'b0;
			SENS_BOFF: sens_hit = boff;
			SENS_ERR:  sens_hit = err;
			SENS_ALL:  sens_hit = (a != b);
		endcase
	endfunction

	// bus decode; zero wait states, no error answer
	assign wr_en     = psel_i && penable_i && pwrite_i;
	assign rd_en     = psel_i && penable_i && !pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = 1'b0;
	assign hit = (paddr_i == ADDR_ENABLE) || (paddr_i == ADDR_FLAGS) ||
		(paddr_i == ADDR_STATUS) || (paddr_i == ADDR_MASK) ||
		(paddr_i == ADDR_WAKE);

	// receiver forced to ok when tx recovers from bus-off
	assign rx_eff = (tx_flag_q == ST_BUS_OFF && tx_state_i == ST_OK) ?
		ST_OK : rx_state_i; // see [R11] [R10]

	// change detection against the latched flags
	assign rx_hit = sens_hit(enable_q[BIT_RXS_HI:BIT_RXS_LO],
		rx_flag_q, rx_eff); // see [R3]
	assign tx_hit = sens_hit(enable_q[BIT_TXS_HI:BIT_TXS_LO],
		tx_flag_q, tx_state_i); // see [R4]
	assign csc_set = !csc_q && (rx_hit || tx_hit);
	// writing one to the flag bit clears it
	assign flags_wr = wr_en && paddr_i == ADDR_FLAGS;
	assign csc_clr  = flags_wr && pwdata_i[FL_CSC];

	// state flags and change flag; set beats clear
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rx_flag_q <= ST_OK;
			tx_flag_q <= ST_OK;
			csc_q     <= 1'b0;
		end else begin
			if (!csc_q) begin
				rx_flag_q <= rx_eff;      // see [R5]
				tx_flag_q <= tx_state_i;  // see [R6]
			end
			csc_q <= csc_set || (csc_q && !csc_clr);
		end
	end

	// event flags held until software clears them
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wake_q <= 1'b0;
			ovr_q  <= 1'b0;
			rxf_q  <= 1'b0;
		end else begin
			wake_q <= events_i.wakeup ||
				(wake_q && !(flags_wr && pwdata_i[FL_WAKE]));
			ovr_q  <= events_i.overrun ||
				(ovr_q && !(flags_wr && pwdata_i[FL_OVR]));
			rxf_q  <= events_i.rx_full ||
				(rxf_q && !(flags_wr && pwdata_i[FL_RXF]));
		end
	end

	// requests gated by the enable bits
	assign wakeup_irq_o = wake_q && enable_q[BIT_WAKE_IE]; // see [R1] [R12]
	assign error_irq_o  = (csc_q && enable_q[BIT_CSC_IE]) ||   // see [R2]
		(ovr_q && enable_q[BIT_OVR_IE]);                  // see [R7] [R12]
	assign rx_irq_o     = rxf_q && enable_q[BIT_RXF_IE];  // see [R8] [R12]
	// both enables needed to leave a low-power mode
	assign recover_o = low_power_i && events_i.wakeup && wake_fn_q &&
		enable_q[BIT_WAKE_IE]; // see [R9]

	// sticky summary status, cleared by a read, set wins
	// only fresh events set a bit (wake, overrun, receive full when enabled; change flag without its enable), so a read really clears it
	assign ev_set = {events_i.rx_full && enable_q[BIT_RXF_IE],
		events_i.overrun && enable_q[BIT_OVR_IE], csc_set,
		events_i.wakeup && enable_q[BIT_WAKE_IE]};
	assign status_d = ev_set |
		((rd_en && paddr_i == ADDR_STATUS) ? '0 : status_q);
	assign irq_o = |(status_q & mask_q);

	// software registers
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			enable_q  <= ENABLE_RESET;
			mask_q    <= MASK_RESET;
			wake_fn_q <= 1'b0;
			status_q  <= '0;
		end else begin
			status_q <= status_d;
			if (wr_en && paddr_i == ADDR_ENABLE)
				enable_q <= pwdata_i[7:0];
			if (wr_en && paddr_i == ADDR_MASK)
				mask_q <= pwdata_i[EV_N-1:0];
			if (wr_en && paddr_i == ADDR_WAKE)
				wake_fn_q <= pwdata_i[0];
		end
	end

	// read mux; unmapped reads return zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (1'b1)
			paddr_i == ADDR_ENABLE: rd_mux[7:0] = enable_q;
			paddr_i == ADDR_FLAGS: rd_mux[7:0] = {wake_q, ovr_q,
				rx_flag_q, tx_flag_q, rxf_q, csc_q};
			paddr_i == ADDR_STATUS: rd_mux[EV_N-1:0] = status_q;
			paddr_i == ADDR_MASK: rd_mux[EV_N-1:0] = mask_q;
			paddr_i == ADDR_WAKE: rd_mux[0] = wake_fn_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// registered read data
	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			prdata_o <= 32'h0000_0000;
		else if (psel_i && !penable_i && !pwrite_i)
			prdata_o <= hit ? rd_mux : 32'h0000_0000;
	end

	// named steps shared by the properties below
	sequence wake_event_s;
		events_i.wakeup && enable_q[BIT_WAKE_IE];
	endsequence
	sequence wake_raised_s;
		wake_q && wakeup_irq_o;
	endsequence
	sequence csc_rise_s;
		!csc_q ##1 csc_q;
	endsequence
	sequence ovr_event_s;
		events_i.overrun && enable_q[BIT_OVR_IE];
	endsequence
	sequence rxf_event_s;
		events_i.rx_full && enable_q[BIT_RXF_IE];
	endsequence
	sequence flags_clear_all_s;
		flags_wr && pwdata_i[FL_WAKE] && pwdata_i[FL_OVR] &&
			pwdata_i[FL_RXF];
	endsequence

	// rx flags freeze while the change flag is pending
	rx_frozen_a: // see [R5]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$past(csc_q) |-> $stable(rx_flag_q))
		else $error("rx flags moved while change pending");
	// tx flags freeze while the change flag is pending
	tx_frozen_a: // see [R6]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$past(csc_q) |-> $stable(tx_flag_q))
		else $error("tx flags moved while change pending");
	// no wake request without its enable
	wake_gate_a: // see [R1]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wakeup_irq_o |-> enable_q[BIT_WAKE_IE] && wake_q)
		else $error("wake request without enable");
	// pending change flag with enable drives the error line
	csc_req_a: // see [R2]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(csc_q && enable_q[BIT_CSC_IE]) |-> error_irq_o)
		else $error("change flag not requested");
	// no sensitivity on either side, no change flag
	rx_none_a: // see [R3]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(enable_q[BIT_RXS_HI:BIT_TXS_LO] == 4'h0 && !csc_q) |=> !csc_q)
		else $error("change flag set with no sensitivity");
	// tx bus-off entry caught at the lowest level
	boff_set_a: // see [R4]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && enable_q[BIT_TXS_HI:BIT_TXS_LO] == SENS_BOFF &&
		tx_flag_q != ST_BUS_OFF && tx_state_i == ST_BUS_OFF) |=> csc_q)
		else $error("bus-off entry missed");
	// overrun flag with enable drives the error line
	ovr_gate_a: // see [R7]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ovr_q && enable_q[BIT_OVR_IE]) |-> error_irq_o)
		else $error("overrun not requested");
	// receive full request follows its enable
	rxf_req_a: // see [R8] [R12]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		events_i.rx_full |=> (rx_irq_o == enable_q[BIT_RXF_IE]))
		else $error("receive full request wrong");
	// tx recovery from bus-off drags the receiver to ok
	rx_forced_a: // see [R11]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && tx_flag_q == ST_BUS_OFF && tx_state_i == ST_OK)
		|=> rx_flag_q == ST_OK)
		else $error("receiver not forced to ok");
	// recovery needs both wake enables
	recover_a: // see [R9]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		recover_o |-> wake_fn_q && enable_q[BIT_WAKE_IE])
		else $error("recovery without both enables");
	// an enabled wake event raises the request next cycle
	wake_req_a: // see [R1]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wake_event_s |=> wake_raised_s)
		else $error("wake request not raised");
	// wake enable clear keeps the line low
	wake_off_a: // see [R1]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!enable_q[BIT_WAKE_IE] |-> !wakeup_irq_o)
		else $error("wake request while disabled");
	// error line low when the change enable is clear and overrun is not enabled and pending
	csc_off_a: // see [R2]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!enable_q[BIT_CSC_IE] && !(ovr_q && enable_q[BIT_OVR_IE]))
		|-> !error_irq_o)
		else $error("error request without source");
	// rx bus-off entry or exit at the lowest level
	rx_boff_a: // see [R3]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && enable_q[BIT_RXS_HI:BIT_RXS_LO] == SENS_BOFF &&
		((rx_flag_q == ST_BUS_OFF) != (rx_eff == ST_BUS_OFF))) |=> csc_q)
		else $error("rx bus-off change missed");
	// rx error entry at the middle level
	rx_err_a: // see [R3]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && enable_q[BIT_RXS_HI:BIT_RXS_LO] == SENS_ERR &&
		rx_flag_q != ST_ERR && rx_eff == ST_ERR) |=> csc_q)
		else $error("rx error entry missed");
	// any rx change at the top level
	rx_all_a: // see [R3]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && enable_q[BIT_RXS_HI:BIT_RXS_LO] == SENS_ALL &&
		rx_flag_q != rx_eff) |=> csc_q)
		else $error("rx change missed");
	// tx error entry at the middle level
	tx_err_a: // see [R4]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && enable_q[BIT_TXS_HI:BIT_TXS_LO] == SENS_ERR &&
		tx_flag_q != ST_ERR && tx_state_i == ST_ERR) |=> csc_q)
		else $error("tx error entry missed");
	// any tx change at the top level
	tx_all_a: // see [R4]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && enable_q[BIT_TXS_HI:BIT_TXS_LO] == SENS_ALL &&
		tx_flag_q != tx_state_i) |=> csc_q)
		else $error("tx change missed");
	// tx level off and no rx hit leaves the flag clear
	tx_none_a: // see [R4]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && enable_q[BIT_TXS_HI:BIT_TXS_LO] == SENS_NONE &&
		!rx_hit) |=> !csc_q)
		else $error("change flag set by masked tx");
	// rx flags track the receiver while nothing is pending
	rx_track_a: // see [R5]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!csc_q |=> rx_flag_q == $past(rx_eff))
		else $error("rx flags not tracking");
	// tx flags track the transmitter while nothing is pending
	tx_track_a: // see [R6]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!csc_q |=> tx_flag_q == $past(tx_state_i))
		else $error("tx flags not tracking");
	// rx flags hold from the cycle after the flag rises
	rx_after_set_a: // see [R5]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		csc_rise_s |=> $stable(rx_flag_q))
		else $error("rx flags moved after change flag");
	// tx flags hold from the cycle after the flag rises
	tx_after_set_a: // see [R6]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		csc_rise_s |=> $stable(tx_flag_q))
		else $error("tx flags moved after change flag");
	// enabled overrun raises the error line next cycle
	ovr_req_a: // see [R7]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ovr_event_s |=> ovr_q && error_irq_o)
		else $error("overrun request not raised");
	// enabled receive full raises the receiver line
	rxf_raise_a: // see [R8]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rxf_event_s |=> rxf_q && rx_irq_o)
		else $error("receive full request not raised");
	// receive full enable clear keeps the line low
	rxf_off_a: // see [R8]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!enable_q[BIT_RXF_IE] |-> !rx_irq_o)
		else $error("receive request while disabled");
	// no recovery outside a low-power mode
	recover_off_a: // see [R9]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!low_power_i |-> !recover_o)
		else $error("recovery outside low power");
	// receiver keeps its own bus-off code
	rx_boff_code_a: // see [R10]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!csc_q && rx_state_i == ST_BUS_OFF &&
		!(tx_flag_q == ST_BUS_OFF && tx_state_i == ST_OK))
		|=> rx_flag_q == ST_BUS_OFF)
		else $error("rx bus-off code lost");
	// an enabled wake event leaves a status bit
	status_wake_a: // see [R12]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wake_event_s |=> status_q[EV_WAKE])
		else $error("wake status not set");
	// unmasked status bit drives the summary line
	irq_level_a: // see [R12]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(status_q[EV_WAKE] && mask_q[EV_WAKE]) |-> irq_o)
		else $error("summary line low with unmasked status");
	// clearing the wake, overrun and receive full flags with no new event drops those three flags
	flags_clear_a: // see [R12]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		flags_clear_all_s ##0 (!events_i.wakeup && !events_i.overrun &&
		!events_i.rx_full) |=> !wake_q && !ovr_q && !rxf_q)
		else $error("event flags not cleared");
	// nothing pending in status keeps the summary low
	irq_off_a: // see [R12]
		assert property (@(posedge clock_i) disable iff (!rst_n_i)
		status_q == '0 |-> !irq_o)
		else $error("summary line high without status");

endmodule // crie_irq_logic

// ---- verilog/crie_pkg.sv ----
// package for the receive interrupt enable and status-change logic
package crie_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_FLAGS  = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK   = 8'h0C;
	localparam logic [7:0] ADDR_WAKE   = 8'h10;
	// enable register field positions
	localparam int BIT_WAKE_IE = 7;
	localparam int BIT_CSC_IE  = 6;
	localparam int BIT_RXS_HI  = 5;
	localparam int BIT_RXS_LO  = 4;
	localparam int BIT_TXS_HI  = 3;
	localparam int BIT_TXS_LO  = 2;
	localparam int BIT_OVR_IE  = 1;
	localparam int BIT_RXF_IE  = 0;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	// sticky event layout for status and mask
	localparam int EV_WAKE = 0;
	localparam int EV_CSC  = 1;
	localparam int EV_OVR  = 2;
	localparam int EV_RXF  = 3;
	localparam int EV_N    = 4;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// error-state codes (receiver also has bus-off)
	typedef enum logic [1:0] {
		ST_OK      = 2'b00,
		ST_WARN    = 2'b01,
		ST_ERR     = 2'b10,
		ST_BUS_OFF = 2'b11
	} crie_state_type;
	// sensitivity levels
	localparam logic [1:0] SENS_NONE = 2'b00;
	localparam logic [1:0] SENS_BOFF = 2'b01;
	localparam logic [1:0] SENS_ERR  = 2'b10;
	localparam logic [1:0] SENS_ALL  = 2'b11;
	// flags register layout: rx code [5:4], tx code [3:2], csc flag [0]
	localparam int FL_RX_LO = 4;
	localparam int FL_TX_LO = 2;
	localparam int FL_CSC   = 0;
	localparam int FL_WAKE  = 7;
	localparam int FL_OVR   = 6;
	localparam int FL_RXF   = 1;
	// event strobes from the controller core
	typedef struct packed {
		logic wakeup;
		logic overrun;
		logic rx_full;
	} crie_event_type;
endpackage

// ---- test/crie_intc_model.sv ----
// stand-in for the cpu interrupt controller, latching request lines
`timescale 1ns/100ps
module crie_intc_model (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	// request lines {irq, rx, error, wakeup}
	input  wire logic [3:0] req_i,
	output logic      [3:0] pend_o
);
	// sampled once per cycle, as a vectored controller would see them
	always_ff @(posedge clock_i) begin
		pend_o <= rst_n_i ? req_i : 4'h0;
	end
endmodule // crie_intc_model

// ---- test/tb.sv ----
// self-checking bench for the interrupt enable and status-change logic
`timescale 1ns/100ps
module tb;
	import crie_pkg::*;
	logic           clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic           lowp = 0, snap = 0;
	logic [7:0]     pa = 8'h00;
	logic [2:0]     ev_s = 3'h0;
	logic [31:0]    pwd = 32'h0000_0000, prd, rnd, v, e;
	logic           pready, pslverr, w_irq, e_irq, r_irq, rec, irq;
	crie_state_type rxs = ST_OK, txs = ST_OK;
	logic [31:0]    expq[$];
	int             err_total = 0, num_checks = 0;
	always #10 clk = ~clk;
	crie_irq_logic u_crie_irq_logic (.clock_i(clk), .rst_n_i(rst_n),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
		.pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
		.pslverr_o(pslverr), .events_i(ev_s), .rx_state_i(rxs),
		.tx_state_i(txs), .low_power_i(lowp), .wakeup_irq_o(w_irq),
		.error_irq_o(e_irq), .rx_irq_o(r_irq), .recover_o(rec), .irq_o(irq));
	crie_intc_model u_crie_intc_model (.clock_i(clk), .rst_n_i(rst_n),
		.req_i({irq, r_irq, e_irq, w_irq}), .pend_o());
	// one apb transfer; waits for pready rather than assuming a latency
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		{psel, pen, pwr, pa, pwd} <= {2'h2, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		{psel, pen} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		expq.push_back(x);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// snapshot of {recover, irq, rx, error, wakeup}
	task automatic chk_out(input logic [4:0] x);
		expq.push_back({27'h0, x});
		@(posedge clk);
		snap <= 1'b1;
		@(posedge clk);
		snap <= 1'b0;
	endtask
	// one-cycle event pulse, outputs snapped while it is high
	task automatic pulse(input logic [2:0] ev, input logic [4:0] x);
		expq.push_back({27'h0, x});
		@(posedge clk);
		ev_s <= ev;
		snap <= 1'b1;
		@(posedge clk);
		ev_s <= 3'h0;
		snap <= 1'b0;
	endtask
	// move one side's state, then read flags and the error request
	task automatic step(input logic side, input crie_state_type st,
		input logic c);
		@(posedge clk);
		if (side) txs <= st;
		else rxs <= st;
		repeat (3) @(posedge clk);
		rd(ADDR_FLAGS, (32'(st) << (side ? 2 : 4)) | 32'(c));
		chk_out({3'h0, c, 1'h0});
		apb(1'b1, ADDR_FLAGS, 32'h0000_0001);
	endtask
	// compares oldest note with whatever result just appeared
	always @(posedge clk) begin
		if (psel && pen && (pready !== 1'b1 || pslverr !== 1'b0)) begin
			err_total++;
			$display("FAIL t=%0t exp=%h got=%h", $time, 2'h2,
				{pready, pslverr});
		end
		if (snap || (psel && pen && !pwr)) begin
			v = snap ? {27'h0, rec, irq, r_irq, e_irq, w_irq} : prd;
			e = expq.pop_front();
			num_checks++;
			if (v !== e) begin
				err_total++;
				$display("FAIL t=%0t exp=%h got=%h", $time, e, v);
			end
		end
	end
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// a hang would otherwise stall the run forever
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		final_report();
	end
	initial begin
		void'($urandom(28));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_out(5'h00);
		rd(ADDR_ENABLE, 32'h0000_0000);
		rd(8'h14, 32'h0000_0000);
		rnd = $urandom;
		apb(1'b1, ADDR_ENABLE, rnd);
		rd(ADDR_ENABLE, {24'h0, rnd[7:0]});
		apb(1'b1, ADDR_ENABLE, 32'h0000_0000);
		apb(1'b1, ADDR_WAKE, 32'h0000_0001);
		lowp <= 1'b1;
		pulse(3'h4, 5'h00);
		chk_out(5'h00);
		apb(1'b1, ADDR_FLAGS, 32'h0000_00C3);
		rd(ADDR_STATUS, 32'h0000_0000);
		apb(1'b1, ADDR_ENABLE, 32'h0000_00C3);
		apb(1'b1, ADDR_MASK, 32'h0000_000F);
		pulse(3'h4, 5'h10);
		chk_out(5'h09);
		pulse(3'h2, 5'h09);
		chk_out(5'h0B);
		pulse(3'h1, 5'h0B);
		chk_out(5'h0F);
		rd(ADDR_STATUS, 32'h0000_000D);
		chk_out(5'h07);
		lowp <= 1'b0;
		apb(1'b1, ADDR_MASK, 32'h0000_0000);
		pulse(3'h4, 5'h07);
		chk_out(5'h07);
		apb(1'b1, ADDR_MASK, 32'h0000_0001);
		chk_out(5'h0F);
		apb(1'b1, ADDR_FLAGS, 32'h0000_00C3);
		chk_out(5'h08);
		rd(ADDR_STATUS, 32'h0000_0001);
		// every sensitivity level on both sides, all four state codes
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, ADDR_ENABLE, 32'h40 | ((k % 4) << (k[2] ? 2 : 4)));
			step(k[2], ST_WARN, (k % 4) == 3);
			step(k[2], ST_ERR, (k % 4) >= 2);
			step(k[2], ST_BUS_OFF, (k % 4) >= 1);
			step(k[2], ST_OK, (k % 4) >= 1);
		end
		// tx leaving bus-off drags rx to ok; the flag then freezes it there
		apb(1'b1, ADDR_ENABLE, 32'h0000_0000);
		rxs <= ST_ERR;
		txs <= ST_BUS_OFF;
		apb(1'b1, ADDR_ENABLE, 32'h0000_0030);
		apb(1'b1, ADDR_FLAGS, 32'h0000_0001);
		rd(ADDR_FLAGS, 32'h0000_002C);
		txs <= ST_OK;
		repeat (3) @(posedge clk);
		rd(ADDR_FLAGS, 32'h0000_0001);
		final_report();
	end
endmodule // tb
